// ---- cpg_map.svh ----
// register map, field positions, reset values and timing figures of the cell protection block
`ifndef CPG_MAP_SVH
`define CPG_MAP_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CPG_IDX_PROT     10'h000
`define CPG_IDX_STAT     10'h001
`define CPG_IDX_VOLT     10'h00C
`define CPG_IDX_CUR      10'h00E
`define CPG_IDX_ACC      10'h010
`define CPG_IDX_BIAS     10'h033

// ---------------------------------------------------------------
// protection register fields
// ---------------------------------------------------------------
`define CPG_B_OV         7
`define CPG_B_UV         6
`define CPG_B_COC        5
`define CPG_B_DOC        4
`define CPG_B_CC         3
`define CPG_B_DC         2
`define CPG_B_CE         1
`define CPG_B_DE         0

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define CPG_B_SLEEP      0
`define CPG_B_RECOV      1
`define CPG_B_PDN        2
`define CPG_B_PUP        3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define CPG_BIAS_RST     8'h00
`define CPG_EN_RST       1'b1

// ---------------------------------------------------------------
// timing and scaling
// ---------------------------------------------------------------
`define CPG_CLK_MHZ      40
`define CPG_REFRESH_US   88000
`define CPG_AVG_N        128
`define CPG_AVG_SH       7
`define CPG_OVD_US       1000
`define CPG_UVD_US       100000
`define CPG_OCD_US       10000
`define CPG_SCD_US       100
`define CPG_ACC_MUL      4
`define CPG_GAIN_SH      7
`define CPG_VOLT_MAX     12'h3CD
`define CPG_CUR_MAX      12'h7FF
`define CPG_CUR_MIN      12'h800

`endif

// ---- cpg_pkg.sv ----
// types and helper functions of the cell protection block
package cpg_pkg;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic {MODE_SLEEP, MODE_ACTIVE} cpg_mode_e;

   typedef struct packed {
      logic        ov;
      logic        uv;
      logic        charge_overcurrent_flag;
      logic        discharge_overcurrent_flag;
   } cpg_cond_s;

   typedef struct packed {
      cpg_mode_e          mode;
      logic               ce;
      logic               de;
      cpg_cond_s          flag;
      cpg_cond_s          act;
      logic [23:0]        c_ov;
      logic [23:0]        c_uv;
      logic [23:0]        c_oc;
      logic [23:0]        c_od;
      logic [23:0]        c_sc;
      logic [15:0]        smp;
      logic [6:0]         avg_n;
      logic signed [18:0] sum;
      logic signed [11:0] cur;
      logic signed [31:0] acc;
      logic [11:0]        volt;
      logic [7:0]         bias;
      logic               cc;
      logic               dc;
      logic [31:0]        rdata;
   } cpg_state_s;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // delay counter: restarts whenever the condition drops
   function automatic logic [23:0] cpg_qual(input logic [23:0] c,
                                            input logic        cond,
                                            input logic [23:0] lim);
      if (!cond) begin
         return 24'h000000;
      end
      return (c < lim) ? c + 24'h000001 : c;
   endfunction : cpg_qual

   function automatic logic signed [11:0] cpg_sat12(input logic signed [19:0] v);
      if (v > 20'sh007FF) begin
         return 12'sh7FF;
      end
      if (v < -20'sh00800) begin
         return -12'sh800;
      end
      return v[11:0];
   endfunction : cpg_sat12

endpackage : cpg_pkg

// ---- cpg_top.sv ----
// cell protection, current and voltage measurement with apb register access
`timescale 1ns/1ps
`include "cpg_map.svh"

module cpg_top
   import cpg_pkg::*;
#(
   parameter logic [23:0] OVD_CYC = 24'(`CPG_OVD_US * `CPG_CLK_MHZ),
   parameter logic [23:0] UVD_CYC = 24'(`CPG_UVD_US * `CPG_CLK_MHZ),
   parameter logic [23:0] OCD_CYC = 24'(`CPG_OCD_US * `CPG_CLK_MHZ),
   parameter logic [23:0] SCD_CYC = 24'(`CPG_SCD_US * `CPG_CLK_MHZ),
   parameter logic [15:0] SMP_CYC = 16'((`CPG_REFRESH_US * `CPG_CLK_MHZ) / `CPG_AVG_N)
) (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // analog comparators and wake switch
   input  wire logic        cell_over_ov_i,
   input  wire logic        cell_below_ce_i,
   input  wire logic        cell_below_uv_i,
   input  wire logic        sense_over_oc_i,
   input  wire logic        sense_under_oc_i,
   input  wire logic        short_over_i,
   input  wire logic        pack_above_supply_i,
   input  wire logic        pack_below_test_i,
   input  wire logic        supply_above_2v2_i,
   input  wire logic        supply_above_3v_i,
   input  wire logic        wake_switch_n_i,
   // converters and trim
   input  wire logic        ext_sense_i,
   input  wire logic [7:0]  cal_gain_i,
   input  wire logic [11:0] cur_sample_i,
   input  wire logic [11:0] volt_sample_i,
   output logic             conv_strobe_o,
   // fet control and pack terminal
   output logic             charge_control_out_o,
   output logic             discharge_control_out_o,
   output logic             pack_pulldown_o,
   output logic             pack_pullup_o,
   output logic             recovery_en_o,
   output logic             sleep_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   cpg_state_s s_q;
   cpg_state_s s_d;

   logic        tick;
   logic        acc_phase;
   logic        wr;
   logic [9:0]  idx;
   logic        hit;
   logic [31:0] rd_mux;

   logic signed [20:0] gained;
   logic signed [19:0] comp;
   logic signed [11:0] corr;
   logic signed [18:0] sum_new;
   logic signed [11:0] avg;
   logic signed [32:0] acc_new;

   assign idx       = paddr[11:2];
   assign acc_phase = psel & penable;
   assign wr        = acc_phase & pwrite;
   assign hit       = (idx == `CPG_IDX_PROT) | (idx == `CPG_IDX_STAT) |
                      (idx == `CPG_IDX_VOLT) | (idx == `CPG_IDX_CUR)  |
                      (idx == `CPG_IDX_ACC)  | (idx == `CPG_IDX_BIAS);
   assign tick      = (s_q.mode == MODE_ACTIVE) && (s_q.smp == SMP_CYC - 16'h0001);

   // ---------------------------------------------------------------
   // measurement arithmetic
   // ---------------------------------------------------------------
   always_comb begin
      gained = $signed(cur_sample_i) * $signed({1'b0, cal_gain_i});
      if (ext_sense_i) begin
         comp = 20'(signed'(cur_sample_i));
      end else begin
         comp = 20'(gained >>> `CPG_GAIN_SH);
      end
      comp    = comp - 20'(signed'(s_q.bias));
      corr    = cpg_sat12(comp);
      sum_new = s_q.sum + 19'(corr);
      avg     = cpg_sat12(20'(sum_new >>> `CPG_AVG_SH));
      // fraction bits in the low half make each average a small step
      acc_new = 33'(s_q.acc) + 33'(avg) * 33'(`CPG_ACC_MUL);
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (idx)
         `CPG_IDX_PROT: begin
            rd_mux[`CPG_B_OV]  = s_q.flag.ov;
            rd_mux[`CPG_B_UV]  = s_q.flag.uv;
            rd_mux[`CPG_B_COC] = s_q.flag.charge_overcurrent_flag;
            rd_mux[`CPG_B_DOC] = s_q.flag.discharge_overcurrent_flag;
            rd_mux[`CPG_B_CC]  = s_q.cc;
            rd_mux[`CPG_B_DC]  = s_q.dc;
            rd_mux[`CPG_B_CE]  = s_q.ce;
            rd_mux[`CPG_B_DE]  = s_q.de;
         end
         `CPG_IDX_STAT: begin
            rd_mux[`CPG_B_SLEEP] = (s_q.mode == MODE_SLEEP);
            rd_mux[`CPG_B_RECOV] = ~supply_above_3v_i;
            rd_mux[`CPG_B_PDN]   = s_q.act.charge_overcurrent_flag;
            rd_mux[`CPG_B_PUP]   = s_q.act.discharge_overcurrent_flag;
         end
         `CPG_IDX_VOLT: rd_mux[11:0] = s_q.volt;
         `CPG_IDX_CUR:  rd_mux[11:0] = s_q.cur;
         `CPG_IDX_ACC:  rd_mux[15:0] = s_q.acc[31:16];
         `CPG_IDX_BIAS: rd_mux[7:0]  = s_q.bias;
         default:       rd_mux       = 32'h00000000;
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;

      // sample pacing and measurement run only while awake
      if (s_q.mode == MODE_ACTIVE) begin
         s_d.smp = tick ? 16'h0000 : s_q.smp + 16'h0001;
      end else begin
         s_d.smp = 16'h0000;
      end
      if (tick) begin
         if (volt_sample_i > `CPG_VOLT_MAX) begin
            s_d.volt = `CPG_VOLT_MAX;
         end else begin
            s_d.volt = volt_sample_i;
         end
         s_d.avg_n = s_q.avg_n + 7'h01;
         s_d.sum   = sum_new;
         if (s_q.avg_n == 7'h7F) begin
            s_d.sum = 19'sh00000;
            s_d.cur = avg;
            if (acc_new > 33'sh07FFFFFFF) begin
               s_d.acc = 32'sh7FFFFFFF;
            end else if (acc_new < -33'sh080000000) begin
               s_d.acc = -32'sh80000000;
            end else begin
               s_d.acc = acc_new[31:0];
            end
         end
      end

      // delay qualification, only while awake
      if (s_q.mode == MODE_ACTIVE) begin
         s_d.c_ov = cpg_qual(s_q.c_ov, cell_over_ov_i, OVD_CYC);
         s_d.c_uv = cpg_qual(s_q.c_uv, cell_below_uv_i, UVD_CYC);
         s_d.c_oc = cpg_qual(s_q.c_oc, sense_over_oc_i, OCD_CYC);
         s_d.c_od = cpg_qual(s_q.c_od, sense_under_oc_i, OCD_CYC);
         s_d.c_sc = cpg_qual(s_q.c_sc, short_over_i, SCD_CYC);
      end else begin
         s_d.c_ov = 24'h000000;
         s_d.c_uv = 24'h000000;
         s_d.c_oc = 24'h000000;
         s_d.c_od = 24'h000000;
         s_d.c_sc = 24'h000000;
      end

      // releases first, so a fresh trip in the same cycle still wins
      if (cell_below_ce_i) begin
         s_d.act.ov = 1'b0;
      end
      if (pack_above_supply_i && supply_above_2v2_i) begin
         s_d.act.uv = 1'b0;
      end
      if (pack_below_test_i) begin
         s_d.act.charge_overcurrent_flag = 1'b0;
      end
      if (!pack_below_test_i) begin
         s_d.act.discharge_overcurrent_flag = 1'b0;
      end

      // flags: host writes 0 to clear, 1 leaves them alone
      if (wr && idx == `CPG_IDX_PROT) begin
         s_d.flag.ov  = s_q.flag.ov  & pwdata[`CPG_B_OV];
         s_d.flag.uv  = s_q.flag.uv  & pwdata[`CPG_B_UV];
         s_d.flag.charge_overcurrent_flag = s_q.flag.charge_overcurrent_flag & pwdata[`CPG_B_COC];
         s_d.flag.discharge_overcurrent_flag = s_q.flag.discharge_overcurrent_flag & pwdata[`CPG_B_DOC];
         s_d.ce       = pwdata[`CPG_B_CE];
         s_d.de       = pwdata[`CPG_B_DE];
      end
      if (wr && idx == `CPG_IDX_ACC) begin
         s_d.acc = {pwdata[15:0], 16'h0000};
      end
      if (wr && idx == `CPG_IDX_BIAS) begin
         s_d.bias = pwdata[7:0];
      end

      // trips
      if (s_q.c_ov == OVD_CYC && cell_over_ov_i) begin
         s_d.act.ov  = 1'b1;
         s_d.flag.ov = 1'b1;
      end
      if (s_q.c_oc == OCD_CYC && sense_over_oc_i) begin
         s_d.act.charge_overcurrent_flag  = 1'b1;
         s_d.flag.charge_overcurrent_flag = 1'b1;
      end
      if (s_q.c_od == OCD_CYC && sense_under_oc_i) begin
         s_d.act.discharge_overcurrent_flag  = 1'b1;
         s_d.flag.discharge_overcurrent_flag = 1'b1;
      end
      if (s_q.c_sc == SCD_CYC && short_over_i) begin
         s_d.act.discharge_overcurrent_flag  = 1'b1;
         s_d.flag.discharge_overcurrent_flag = 1'b1;
      end

      // power mode
      unique case (s_q.mode)
         MODE_ACTIVE: begin
            if (s_q.c_uv == UVD_CYC && cell_below_uv_i) begin
               s_d.act.uv  = 1'b1;
               s_d.flag.uv = 1'b1;
               s_d.mode    = MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            // a charger wakes only once the supply has cleared 2.2 V
            if (!wake_switch_n_i || (pack_above_supply_i && supply_above_2v2_i)) begin
               s_d.mode = MODE_ACTIVE;
               s_d.ce   = 1'b1;
               s_d.de   = 1'b1;
            end
         end
      endcase

      s_d.cc = s_d.act.ov | s_d.act.uv | s_d.act.charge_overcurrent_flag | ~s_d.ce |
               (s_d.mode == MODE_SLEEP);
      s_d.dc = s_d.act.uv | s_d.act.charge_overcurrent_flag | s_d.act.discharge_overcurrent_flag | ~s_d.de |
               (s_d.mode == MODE_SLEEP);

      // read data is captured in the setup cycle
      if (psel && !penable) begin
         s_d.rdata = rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s_q       <= '0;
         s_q.mode  <= MODE_SLEEP;
         s_q.ce    <= `CPG_EN_RST;
         s_q.de    <= `CPG_EN_RST;
         s_q.bias  <= `CPG_BIAS_RST;
         s_q.cc    <= 1'b1;
         s_q.dc    <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata                  = s_q.rdata;
   assign pready                  = acc_phase;
   assign pslverr                 = acc_phase & ~hit;
   assign conv_strobe_o           = tick;
   assign charge_control_out_o    = s_q.cc;
   assign discharge_control_out_o = s_q.dc;
   assign pack_pulldown_o         = s_q.act.charge_overcurrent_flag;
   assign pack_pullup_o           = s_q.act.discharge_overcurrent_flag;
   assign recovery_en_o           = ~supply_above_3v_i;
   assign sleep_o                 = (s_q.mode == MODE_SLEEP);

endmodule : cpg_top

// ---- cpg_chk_sva.sv ----
// assertion checker for the cell protection block
`timescale 1ns/1ps
module cpg_chk_sva #(
   parameter logic [23:0] OVD_CYC = 24'h000004,
   parameter logic [23:0] UVD_CYC = 24'h000008,
   parameter logic [23:0] SCD_CYC = 24'h000003
) (
   // clock, reset and apb
   input wire logic clk_sys_i, rst_n_i, psel, penable, pready,
   // comparators
   input wire logic cell_over_ov_i, cell_below_uv_i, short_over_i, pack_below_test_i, supply_above_3v_i,
   // outputs
   input wire logic conv_strobe_o, charge_control_out_o, discharge_control_out_o,
   input wire logic pack_pulldown_o, pack_pullup_o, recovery_en_o, sleep_o
);
   // runs of uninterrupted active-mode conditions, cleared by any gap
   logic [23:0] ov_run_q, uv_run_q, sc_run_q;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         ov_run_q <= 24'h000000;
         uv_run_q <= 24'h000000;
         sc_run_q <= 24'h000000;
      end else begin
         ov_run_q <= (!sleep_o && cell_over_ov_i) ? ov_run_q + 24'h000001 : 24'h000000;
         uv_run_q <= (!sleep_o && cell_below_uv_i) ? uv_run_q + 24'h000001 : 24'h000000;
         sc_run_q <= (!sleep_o && short_over_i) ? sc_run_q + 24'h000001 : 24'h000000;
      end
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   AST_OV_TRIP: assert property (ov_run_q > OVD_CYC |-> charge_control_out_o)
      else $error("overvoltage did not turn charge fet off");
   AST_UV_TRIP: assert property (uv_run_q > UVD_CYC |-> sleep_o && charge_control_out_o && discharge_control_out_o)
      else $error("undervoltage did not shut down");
   AST_SC_TRIP: assert property (sc_run_q > SCD_CYC |-> discharge_control_out_o)
      else $error("short circuit did not turn discharge fet off");
   AST_SLEEP_OFF: assert property (sleep_o |-> charge_control_out_o && discharge_control_out_o)
      else $error("fet on in sleep");
   AST_PULLDOWN: assert property (pack_pulldown_o |-> charge_control_out_o && discharge_control_out_o)
      else $error("pull-down without both fets off");
   AST_PULLUP: assert property (pack_pullup_o |-> discharge_control_out_o)
      else $error("pull-up with discharge fet on");
   AST_PULLUP_REL: assert property ($fell(pack_pullup_o) |-> !$past(pack_below_test_i))
      else $error("pull-up released while pack low");
   AST_RECOVERY: assert property (recovery_en_o == !supply_above_3v_i)
      else $error("recovery path wrong");
   AST_STROBE: assert property (conv_strobe_o |-> !sleep_o ##1 !conv_strobe_o [*3])
      else $error("conversion strobe misplaced");
   AST_APB_READY: assert property (psel && penable |-> pready)
      else $error("no ready in access phase");
   cover property (ov_run_q > OVD_CYC);
   cover property ($rose(pack_pulldown_o));
   cover property ($fell(sleep_o));
endmodule : cpg_chk_sva

bind cpg_top cpg_chk_sva #(.OVD_CYC(OVD_CYC), .UVD_CYC(UVD_CYC), .SCD_CYC(SCD_CYC)) i_chk (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pready(pready),
   .cell_over_ov_i(cell_over_ov_i), .cell_below_uv_i(cell_below_uv_i), .short_over_i(short_over_i),
   .pack_below_test_i(pack_below_test_i), .supply_above_3v_i(supply_above_3v_i),
   .conv_strobe_o(conv_strobe_o), .charge_control_out_o(charge_control_out_o),
   .discharge_control_out_o(discharge_control_out_o), .pack_pulldown_o(pack_pulldown_o),
   .pack_pullup_o(pack_pullup_o), .recovery_en_o(recovery_en_o), .sleep_o(sleep_o));

// ---- cpg_fet_model.sv ----
// model of the external fets and the pack terminal
`timescale 1ns/1ps
module cpg_fet_model (
   // clock
   input  wire logic clk_sys_i,
   // from the block
   input  wire logic dc_i,
   input  wire logic pd_i,
   input  wire logic pu_i,
   // pack conditions
   input  wire logic charger_i,
   input  wire logic load_i,
   input  wire logic slow_i,
   // to the block
   output logic      pack_above_o,
   output logic      pack_below_o
);
   logic below_now, below_q;
   // a conducting discharge fet ties the pack to the cell; a floating pack flips so no stale level survives
   assign below_now = charger_i ? 1'b0 : load_i ? 1'b1 : pd_i ? 1'b1 : pu_i ? 1'b0 :
                      dc_i ? (below_q !== 1'b1) : 1'b0;
   always_ff @(posedge clk_sys_i) begin
      below_q <= below_now;
   end
   assign pack_below_o = slow_i ? below_q : below_now;
   assign pack_above_o = charger_i;
endmodule : cpg_fet_model

// ---- test_cell_protection_and_gauge.sv ----
// self-checking testbench of the cell protection block
`timescale 1ns/1ps
`include "cpg_map.svh"
module test_cell_protection_and_gauge;
   localparam logic [11:0] A_PROT = {`CPG_IDX_PROT, 2'b00};
   localparam logic [11:0] A_STAT = {`CPG_IDX_STAT, 2'b00};
   localparam logic [11:0] A_VOLT = {`CPG_IDX_VOLT, 2'b00};
   localparam logic [11:0] A_CUR  = {`CPG_IDX_CUR, 2'b00};
   localparam logic [11:0] A_ACC  = {`CPG_IDX_ACC, 2'b00};
   localparam logic [11:0] A_BIAS = {`CPG_IDX_BIAS, 2'b00};
   logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0] paddr, cur_sample_i, volt_sample_i, smp;
   logic [31:0] pwdata, prdata, rdat, rnd;
   logic [7:0]  cal_gain_i, bia;
   logic cell_over_ov_i, cell_below_ce_i, cell_below_uv_i, sense_over_oc_i, sense_under_oc_i, short_over_i;
   logic pack_above, pack_below, supply_above_2v2_i, supply_above_3v_i, wake_switch_n_i, ext_sense_i;
   logic conv_strobe_o, cc, dc, pd, pu, recovery_en_o, sleep_o, charger, load, slow;
   int   err_total, cmp_count;

   cpg_top #(.OVD_CYC(24'h000004), .UVD_CYC(24'h000008), .OCD_CYC(24'h000004), .SCD_CYC(24'h000003),
      .SMP_CYC(16'h0004)) i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cell_over_ov_i(cell_over_ov_i), .cell_below_ce_i(cell_below_ce_i), .cell_below_uv_i(cell_below_uv_i),
      .sense_over_oc_i(sense_over_oc_i), .sense_under_oc_i(sense_under_oc_i), .short_over_i(short_over_i),
      .pack_above_supply_i(pack_above), .pack_below_test_i(pack_below),
      .supply_above_2v2_i(supply_above_2v2_i), .supply_above_3v_i(supply_above_3v_i),
      .wake_switch_n_i(wake_switch_n_i), .ext_sense_i(ext_sense_i), .cal_gain_i(cal_gain_i),
      .cur_sample_i(cur_sample_i), .volt_sample_i(volt_sample_i), .conv_strobe_o(conv_strobe_o),
      .charge_control_out_o(cc), .discharge_control_out_o(dc), .pack_pulldown_o(pd),
      .pack_pullup_o(pu), .recovery_en_o(recovery_en_o), .sleep_o(sleep_o));

   cpg_fet_model i_fet (.clk_sys_i(clk_sys_i), .dc_i(dc), .pd_i(pd), .pu_i(pu), .charger_i(charger),
      .load_i(load), .slow_i(slow), .pack_above_o(pack_above), .pack_below_o(pack_below));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // expected current for a constant sample: average equals the corrected sample
   function automatic logic [31:0] exp_cur(input int s, input int b);
      int v;
      v = s - b;
      if (v > 2047) v = 2047;
      if (v < -2048) v = -2048;
      return 32'(v) & 32'h00000FFF;
   endfunction : exp_cur
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t register got %h expected %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_bit(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t pin got %b expected %b", $time, g, e);
      end
   endtask : chk_bit
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : tick
   // holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      tick(1);
      while (pready !== 1'b1) begin
         tick(1);
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk_word(rdat, e);
   endtask : rd
   task automatic pins(input logic ec, input logic ed);
      chk_bit(cc, ec);
      chk_bit(dc, ed);
   endtask : pins
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = !clk_sys_i;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      summarize();
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_n_i, psel, penable, pwrite, paddr, pwdata, cell_over_ov_i, cell_below_ce_i} = '0;
      {cell_below_uv_i, sense_over_oc_i, sense_under_oc_i, short_over_i, charger, load, slow} = '0;
      {supply_above_2v2_i, supply_above_3v_i, wake_switch_n_i, ext_sense_i} = 4'hF;
      {cur_sample_i, volt_sample_i, err_total, cmp_count} = '0;
      cal_gain_i = 8'h80;
      rnd = 32'h00007912;
      tick(6);
      rst_n_i <= 1'b1;
      rd(A_PROT, 32'h0000000F);
      rd(A_BIAS, 32'h00000000);
      chk_bit(sleep_o, 1'b1);
      apb(1'b0, 12'hFFC, 32'h00000000);
      chk_bit(rerr, 1'b1);
      chk_word(rdat, 32'h00000000);
      wake_switch_n_i <= 1'b0;
      tick(3);
      wake_switch_n_i <= 1'b1;
      tick(2);
      pins(1'b0, 1'b0);
      $display("test reset and wake finished");
      cell_over_ov_i <= 1'b1;
      tick(4);
      cell_over_ov_i <= 1'b0;
      tick(2);
      pins(1'b0, 1'b0);
      cell_over_ov_i <= 1'b1;
      tick(6);
      pins(1'b1, 1'b0);
      rd(A_PROT, 32'h0000008B);
      cell_over_ov_i  <= 1'b0;
      cell_below_ce_i <= 1'b1;
      tick(3);
      pins(1'b0, 1'b0);
      rd(A_PROT, 32'h00000083);
      cell_below_ce_i <= 1'b0;
      apb(1'b1, A_PROT, 32'h00000003);
      $display("test overvoltage finished");
      charger         <= 1'b1;
      sense_over_oc_i <= 1'b1;
      tick(6);
      sense_over_oc_i <= 1'b0;
      pins(1'b1, 1'b1);
      chk_bit(pd, 1'b1);
      charger <= 1'b0;
      tick(4);
      pins(1'b0, 1'b0);
      rd(A_PROT, 32'h00000023);
      apb(1'b1, A_PROT, 32'h00000003);
      for (int i = 0; i < 2; i++) begin
         load <= 1'b1;
         slow <= i[0];
         {sense_under_oc_i, short_over_i} <= (i == 0) ? 2'b10 : 2'b01;
         tick(6);
         {sense_under_oc_i, short_over_i} <= 2'b00;
         pins(1'b0, 1'b1);
         chk_bit(pu, 1'b1);
         load <= 1'b0;
         tick(4);
         pins(1'b0, 1'b0);
         rd(A_PROT, 32'h00000013);
         apb(1'b1, A_PROT, 32'h00000003);
      end
      $display("test overcurrent finished");
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, A_PROT, 32'(k));
         tick(1);
         pins(!k[1], !k[0]);
      end
      $display("test enable bits finished");
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         smp = (i == 0) ? rnd[11:0] : (i == 1) ? 12'h800 : 12'h7FF;
         bia = (i == 0) ? rnd[23:16] : (i == 1) ? 8'h05 : 8'hFD;
         apb(1'b1, A_BIAS, {24'h000000, bia});
         ext_sense_i  <= i[0];
         cur_sample_i <= smp;
         tick(1040);
         rd(A_CUR, exp_cur(int'($signed(smp)), int'($signed(bia))));
      end
      volt_sample_i <= 12'hFFF;
      tick(12);
      rd(A_VOLT, 32'(`CPG_VOLT_MAX));
      rnd = lfsr(rnd);
      volt_sample_i <= rnd[11:0] % `CPG_VOLT_MAX;
      tick(12);
      rd(A_VOLT, 32'(rnd[11:0] % `CPG_VOLT_MAX));
      cur_sample_i <= 12'h000;
      apb(1'b1, A_BIAS, 32'h00000000);
      tick(1040);
      apb(1'b1, A_ACC, 32'h00001234);
      rd(A_ACC, 32'h00001234);
      apb(1'b1, A_ACC, 32'h00008000);
      cur_sample_i <= 12'h800;
      tick(1040);
      rd(A_ACC, 32'h00008000);
      apb(1'b1, A_ACC, 32'h00000000);
      tick(1040);
      rd(A_ACC, 32'h0000FFFF);
      $display("test measurement finished");
      apb(1'b1, A_PROT, 32'h00000000);
      cell_below_uv_i <= 1'b1;
      tick(10);
      cell_below_uv_i <= 1'b0;
      chk_bit(sleep_o, 1'b1);
      pins(1'b1, 1'b1);
      supply_above_2v2_i <= 1'b0;
      supply_above_3v_i  <= 1'b0;
      charger            <= 1'b1;
      tick(4);
      chk_bit(sleep_o, 1'b1);
      chk_bit(recovery_en_o, 1'b1);
      rd(A_STAT, 32'h00000003);
      supply_above_2v2_i <= 1'b1;
      supply_above_3v_i  <= 1'b1;
      tick(4);
      chk_bit(sleep_o, 1'b0);
      rd(A_PROT, 32'h00000043);
      $display("test undervoltage finished");
      summarize();
   end
endmodule : test_cell_protection_and_gauge
